// ==== hw/adc_dev_end.sv ====
// converter end: reset sampling, filter settling flag, serial register writes and read-back frames
// assumes host pins are asynchronous to clk_sys_i and are sampled through two flip-flops
`timescale 1ns/10ps
module adc_dev_end
  import adc_seq_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  adc_link_if.dev          link,
  input  wire logic [1:0]  dec_rate_i,
  output wire logic        in_reset_o,
  output wire logic        settled_flag_o,
  output wire logic        powered_down_o,
  output wire logic        low_power_o,
  output wire logic        ref_buf_off_o,
  output wire logic        amp_off_o,
  output wire logic [15:0] gain_o,
  output wire logic [15:0] ovr_thr_o
);
  typedef struct packed {
    logic [2:0]  mclk_s;
    logic [1:0]  rst_s;
    logic [1:0]  sync_s;
    logic [1:0]  wr_fs_s;
    logic [1:0]  sdi_s;
    logic        in_reset;
    logic        sync_req;
    logic [6:0]  settle_cnt;
    logic        settled;
    logic [3:0]  sclk_div;
    logic        sclk;
    logic        rx_on;
    logic [5:0]  rx_cnt;
    logic [31:0] rx_sh;
    logic [15:0] ctrl;
    logic [15:0] gain;
    logic [15:0] ovr;
    logic        tx_pend;
    logic [31:0] tx_word;
    logic        tx_on;
    logic [5:0]  tx_cnt;
    logic        sdo;
    logic        fso_n;
  } dev_st_t;

  dev_st_t s_r;
  dev_st_t s_nxt;

  // status word as returned in read-back frames
  function automatic logic [15:0] stat_word(input dev_st_t s, input logic [1:0] dec);
    logic [15:0] w;
    w               = STAT_FIXED;
    w[STAT_PART]    = PART_BIT;
    w[STAT_SETTLED] = s.settled;
    w[STAT_LPWR]    = s.ctrl[CTRL_LPWR];
    w[STAT_REF_OFF] = s.ctrl[CTRL_REF_OFF];
    w[STAT_AMP_OFF] = s.ctrl[CTRL_AMP_OFF];
    w[1:0]          = dec;
    return w;
  endfunction

  // next-state logic for the whole end
  always_comb begin
    logic        mrise;
    logic        tick;
    logic [31:0] word;
    logic [15:0] sel;
    mrise = 1'b0;
    tick  = 1'b0;
    word  = '0;
    sel   = '0;
    s_nxt = s_r;
    // pin sampling: first stage only feeds the second
    s_nxt.mclk_s = {s_r.mclk_s[1:0], link.mclk};
    s_nxt.rst_s  = {s_r.rst_s[0], link.reset_powerdown_n};
    s_nxt.sync_s = {s_r.sync_s[0], link.sync_n};
    s_nxt.wr_fs_s = {s_r.wr_fs_s[0], link.frame_sync_in_n};
    s_nxt.sdi_s  = {s_r.sdi_s[0], link.sdi};
    mrise = s_r.mclk_s[1] & ~s_r.mclk_s[2];
    s_nxt.sync_req = 1'b0;

    // reset level is only looked at on master-clock rising edges
    if (mrise) begin
      s_nxt.in_reset = ~s_r.rst_s[1];
    end

    // settling restarts on reset and on any sync, pin or register
    if (s_r.in_reset || s_r.sync_req || (mrise && !s_r.sync_s[1])) begin
      s_nxt.settle_cnt = '0;
      s_nxt.settled    = 1'b0;
    end else if (mrise && !s_r.settled) begin
      if (s_r.settle_cnt == 7'(SETTLE_MCLK - 1)) begin
        s_nxt.settled = 1'b1;
      end else begin
        s_nxt.settle_cnt = s_r.settle_cnt + 7'd1;
      end
    end

    // free-running serial clock from the internal clock
    tick = (s_r.sclk_div == 4'(SCLK_HALF - 1));
    s_nxt.sclk_div = tick ? 4'd0 : s_r.sclk_div + 4'd1;
    if (tick) begin
      s_nxt.sclk = ~s_r.sclk;
    end

    // write frames: frame sync checked on falling edges, data from the next one on
    if (tick && s_r.sclk) begin
      if (!s_r.rx_on) begin
        if (!s_r.wr_fs_s[1]) begin
          s_nxt.rx_on  = 1'b1;
          s_nxt.rx_cnt = '0;
        end
      end else begin
        word         = {s_r.rx_sh[30:0], s_r.sdi_s[1]};
        s_nxt.rx_sh  = word;
        s_nxt.rx_cnt = s_r.rx_cnt + 6'd1;
        if (s_r.rx_cnt == 6'(FRAME_BITS - 1)) begin
          s_nxt.rx_on = 1'b0;
          // address half first, then the data word
          unique case (word[31:16])
            ADDR_CTRL: begin
              s_nxt.ctrl     = word[15:0] & ~CTRL_SELF_CLR;
              s_nxt.sync_req = word[CTRL_SYNC];
              if (word[CTRL_RD_OVR]) begin
                sel = s_r.ovr;
              end else if (word[CTRL_RD_GAIN]) begin
                sel = s_r.gain;
              end else begin
                sel = stat_word(s_r, dec_rate_i);
              end
              if (word[CTRL_RD_OVR] | word[CTRL_RD_GAIN] | word[CTRL_RD_STAT]) begin
                s_nxt.tx_pend = 1'b1;
                s_nxt.tx_word = {sel, stat_word(s_r, dec_rate_i)};
              end
            end
            ADDR_GAIN: s_nxt.gain = word[15:0];
            ADDR_OVR:  s_nxt.ovr  = word[15:0];
            default:   ;  // unmapped addresses are dropped
          endcase
        end
      end
    end

    // read-back frame: data changes on rising edges, frame sync low for 32 bits
    if (tick && !s_r.sclk) begin
      if (s_r.tx_on) begin
        if (s_r.tx_cnt == 6'(FRAME_BITS)) begin
          s_nxt.tx_on = 1'b0;
          s_nxt.fso_n = 1'b1;
          s_nxt.sdo   = 1'b0;
        end else begin
          s_nxt.sdo     = s_r.tx_word[31];
          s_nxt.tx_word = {s_r.tx_word[30:0], 1'b0};
          s_nxt.tx_cnt  = s_r.tx_cnt + 6'd1;
        end
      end else if (s_r.tx_pend) begin
        s_nxt.tx_pend = 1'b0;
        s_nxt.tx_on   = 1'b1;
        s_nxt.fso_n   = 1'b0;
        s_nxt.sdo     = s_r.tx_word[31];
        s_nxt.tx_word = {s_r.tx_word[30:0], 1'b0};
        s_nxt.tx_cnt  = 6'd1;
      end
    end

    // reset puts every register back to its default and drops serial traffic
    if (s_r.in_reset) begin
      s_nxt.ctrl    = CTRL_RST;
      s_nxt.gain    = GAIN_RST;
      s_nxt.ovr     = OVR_RST;
      s_nxt.rx_on   = 1'b0;
      s_nxt.tx_pend = 1'b0;
      s_nxt.tx_on   = 1'b0;
      s_nxt.fso_n   = 1'b1;
      s_nxt.sdo     = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_r          <= '0;
      s_r.in_reset <= 1'b1;
      s_r.ctrl     <= CTRL_RST;
      s_r.gain     <= GAIN_RST;
      s_r.ovr      <= OVR_RST;
      s_r.fso_n    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // pins and flags come straight from the state register
  assign link.serial_clock_out = s_r.sclk;
  assign link.sdo              = s_r.sdo;
  assign link.frame_sync_out_n = s_r.fso_n;
  assign in_reset_o            = s_r.in_reset;
  assign settled_flag_o        = s_r.settled;
  assign powered_down_o        = s_r.ctrl[CTRL_PWR_DOWN];
  assign low_power_o           = s_r.ctrl[CTRL_LPWR];
  assign ref_buf_off_o         = s_r.ctrl[CTRL_REF_OFF];
  assign amp_off_o             = s_r.ctrl[CTRL_AMP_OFF];
  assign gain_o                = s_r.gain;
  assign ovr_thr_o             = s_r.ovr;
endmodule

// ==== hw/adc_seq_pkg.sv ====
// shared constants for the converter start-up link: timing counts, register map, frame layout
// assumes a single 20 MHz system clock on both ends; master and serial clocks are derived from it
package adc_seq_pkg;
  // system clock
  localparam int unsigned CLK_HZ          = 20_000_000;
  // master clock half period in system cycles (2.5 MHz master clock)
  localparam int unsigned MCLK_HALF       = 4;
  // serial clock half period; long enough to cover two-stage pin sampling on both ends
  localparam int unsigned SCLK_HALF       = 8;
  // start-up timing, in master-clock periods
  localparam int unsigned PWR_MCLK        = 2;
  localparam int unsigned RST_LOW_MCLK    = 1;
  localparam int unsigned POST_RST_MCLK   = 2;
  localparam int unsigned SYNC_LOW_MCLK   = 4;
  // filter settling interval in master-clock rising edges
  localparam int unsigned SETTLE_MCLK     = 64;
  // serial frame layout
  localparam int unsigned FRAME_BITS      = 32;
  localparam int unsigned WORD_BITS       = 16;
  // register addresses
  localparam logic [15:0] ADDR_CTRL       = 16'h0001;
  localparam logic [15:0] ADDR_GAIN       = 16'h0004;
  localparam logic [15:0] ADDR_OVR        = 16'h0005;
  // reset values
  localparam logic [15:0] CTRL_RST        = 16'h0000;
  localparam logic [15:0] GAIN_RST        = 16'hA000;
  localparam logic [15:0] OVR_RST         = 16'hCCCC;
  // control field positions
  localparam int unsigned CTRL_RD_OVR     = 14;
  localparam int unsigned CTRL_RD_GAIN    = 13;
  localparam int unsigned CTRL_RD_STAT    = 11;
  localparam int unsigned CTRL_SYNC       = 9;
  localparam int unsigned CTRL_PWR_DOWN   = 3;
  localparam int unsigned CTRL_LPWR       = 2;
  localparam int unsigned CTRL_REF_OFF    = 1;
  localparam int unsigned CTRL_AMP_OFF    = 0;
  // bits that clear themselves after acting
  localparam logic [15:0] CTRL_SELF_CLR   = 16'h7A00;
  // status field positions and constant bits
  localparam int unsigned STAT_PART       = 15;
  localparam int unsigned STAT_SETTLED    = 10;
  localparam int unsigned STAT_LPWR       = 9;
  localparam int unsigned STAT_REF_OFF    = 4;
  localparam int unsigned STAT_AMP_OFF    = 3;
  localparam logic [15:0] STAT_FIXED      = 16'h4840;
  // part bit of the status word; arbitrary value
  localparam logic        PART_BIT        = 1'b0;

  // host sequencing states
  typedef enum logic [2:0] {
    ST_PWR   = 3'b000,
    ST_RST   = 3'b001,
    ST_WAIT  = 3'b010,
    ST_SYNC  = 3'b011,
    ST_IDLE  = 3'b100,
    ST_WRITE = 3'b101
  } host_st_t;
endpackage

// ==== hw/adc_link_if.sv ====
// pin bundle between the converter end and its host controller
// assumes both ends run on the same system clock; all pins are one-way
`timescale 1ns/10ps
interface adc_link_if;
  logic mclk;
  logic reset_powerdown_n;
  logic sync_n;
  logic frame_sync_in_n;
  logic sdi;
  logic serial_clock_out;
  logic sdo;
  logic frame_sync_out_n;

  modport dev (
    input  mclk,
    input  reset_powerdown_n,
    input  sync_n,
    input  frame_sync_in_n,
    input  sdi,
    output serial_clock_out,
    output sdo,
    output frame_sync_out_n
  );

  modport host (
    output mclk,
    output reset_powerdown_n,
    output sync_n,
    output frame_sync_in_n,
    output sdi,
    input  serial_clock_out,
    input  sdo,
    input  frame_sync_out_n
  );
endinterface

// ==== hw/adc_host_end.sv ====
// host end: drives master clock, reset and sync in the start-up order, writes registers, takes read-back frames
// assumes the converter makes the serial clock; its pins are sampled through two flip-flops here
`timescale 1ns/10ps
module adc_host_end
  import adc_seq_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  adc_link_if.host         link,
  input  wire logic        sync_en_i,
  input  wire logic        sync_req_i,
  input  wire logic        wr_req_i,
  input  wire logic [15:0] wr_addr_i,
  input  wire logic [15:0] wr_data_i,
  output wire logic        ready_o,
  output wire logic        rd_valid_o,
  output wire logic [31:0] rd_word_o
);
  typedef struct packed {
    host_st_t    st;
    logic [1:0]  mdiv;
    logic        mclk;
    logic [2:0]  mcnt;
    logic        rst_n;
    logic        sync_n;
    logic        wr_fs_n;
    logic        sdi;
    logic        ready;
    logic [31:0] tx_sh;
    logic [5:0]  bcnt;
    logic [2:0]  sclk_s;
    logic [1:0]  sdo_s;
    logic [1:0]  fso_s;
    logic [31:0] rx_sh;
    logic [4:0]  rx_cnt;
    logic        rd_valid;
    logic [31:0] rd_word;
  } host_s_t;

  host_s_t s_r;
  host_s_t s_nxt;

  // next-state logic
  always_comb begin
    logic mtick;
    logic mfall;
    logic mrise;
    logic srise;
    logic sfall;
    mtick = 1'b0;
    mfall = 1'b0;
    mrise = 1'b0;
    srise = 1'b0;
    sfall = 1'b0;
    s_nxt = s_r;
    // master clock divider; runs from reset release on, before any other pin moves
    mtick = (s_r.mdiv == 2'(MCLK_HALF - 1));
    s_nxt.mdiv = mtick ? 2'd0 : s_r.mdiv + 2'd1;
    if (mtick) begin
      s_nxt.mclk = ~s_r.mclk;
    end
    mfall = mtick & s_r.mclk;
    mrise = mtick & ~s_r.mclk;

    // serial pins from the converter; first stage only feeds the second
    s_nxt.sclk_s = {s_r.sclk_s[1:0], link.serial_clock_out};
    s_nxt.sdo_s  = {s_r.sdo_s[0], link.sdo};
    s_nxt.fso_s  = {s_r.fso_s[0], link.frame_sync_out_n};
    srise = s_r.sclk_s[1] & ~s_r.sclk_s[2];
    sfall = ~s_r.sclk_s[1] & s_r.sclk_s[2];
    s_nxt.rd_valid = 1'b0;

    unique case (s_r.st)
      // let the master clock run a few periods first
      ST_PWR: begin
        if (mfall) begin
          if (s_r.mcnt == 3'(PWR_MCLK - 1)) begin
            s_nxt.st    = ST_RST;
            s_nxt.mcnt  = '0;
            s_nxt.rst_n = 1'b0;
          end else begin
            s_nxt.mcnt = s_r.mcnt + 3'd1;
          end
        end
      end
      // reset edges placed on master falling edges, away from the sampling edge
      ST_RST: begin
        if (mfall) begin
          if (s_r.mcnt == 3'(RST_LOW_MCLK - 1)) begin
            s_nxt.st    = ST_WAIT;
            s_nxt.mcnt  = '0;
            s_nxt.rst_n = 1'b1;
          end else begin
            s_nxt.mcnt = s_r.mcnt + 3'd1;
          end
        end
      end
      // settle-out time after release before anything else happens
      ST_WAIT: begin
        if (mfall) begin
          if (s_r.mcnt == 3'(POST_RST_MCLK - 1)) begin
            s_nxt.mcnt = '0;
            s_nxt.st   = sync_en_i ? ST_SYNC : ST_IDLE;
            s_nxt.ready = ~sync_en_i;
          end else begin
            s_nxt.mcnt = s_r.mcnt + 3'd1;
          end
        end
      end
      // sync edges placed on master rising edges; low for the full count
      ST_SYNC: begin
        if (mrise) begin
          if (s_r.sync_n) begin
            s_nxt.sync_n = 1'b0;
            s_nxt.mcnt   = '0;
          end else if (s_r.mcnt == 3'(SYNC_LOW_MCLK - 1)) begin
            s_nxt.sync_n = 1'b1;
            s_nxt.st     = ST_IDLE;
            s_nxt.ready  = 1'b1;
          end else begin
            s_nxt.mcnt = s_r.mcnt + 3'd1;
          end
        end
      end
      // a write wins over a sync asked for in the same cycle
      ST_IDLE: begin
        if (wr_req_i) begin
          s_nxt.st    = ST_WRITE;
          s_nxt.ready = 1'b0;
          s_nxt.tx_sh = {wr_addr_i, wr_data_i};
          s_nxt.bcnt  = '0;
        end else if (sync_req_i) begin
          s_nxt.st    = ST_SYNC;
          s_nxt.ready = 1'b0;
        end
      end
      // frame sync goes low one serial period ahead of the first data bit
      ST_WRITE: begin
        if (srise) begin
          s_nxt.bcnt = s_r.bcnt + 6'd1;
          if (s_r.bcnt == 6'd0) begin
            s_nxt.wr_fs_n = 1'b0;
          end else if (s_r.bcnt == 6'(FRAME_BITS + 1)) begin
            s_nxt.wr_fs_n = 1'b1;
            s_nxt.sdi   = 1'b0;
            s_nxt.st    = ST_IDLE;
            s_nxt.ready = 1'b1;
          end else begin
            s_nxt.sdi   = s_r.tx_sh[31];
            s_nxt.tx_sh = {s_r.tx_sh[30:0], 1'b0};
          end
        end
      end
      default: begin
        s_nxt.st = ST_PWR;
      end
    endcase

    // read-back frames are shifted in on serial falling edges while frame sync is low
    if (sfall && !s_r.fso_s[1]) begin
      s_nxt.rx_sh  = {s_r.rx_sh[30:0], s_r.sdo_s[1]};
      s_nxt.rx_cnt = s_r.rx_cnt + 5'd1;
      if (s_r.rx_cnt == 5'(FRAME_BITS - 1)) begin
        s_nxt.rd_valid = 1'b1;
        s_nxt.rd_word  = {s_r.rx_sh[30:0], s_r.sdo_s[1]};
      end
    end else if (s_r.fso_s[1]) begin
      s_nxt.rx_cnt = '0;  // a cut-short frame does not leak into the next
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_r        <= '0;
      s_r.st     <= ST_PWR;
      s_r.rst_n  <= 1'b1;
      s_r.sync_n <= 1'b1;
      s_r.wr_fs_n <= 1'b1;
      s_r.sclk_s  <= '0;
      s_r.fso_s  <= 2'b11;
    end else begin
      s_r <= s_nxt;
    end
  end

  // pins and user outputs come straight from the state register
  assign link.mclk              = s_r.mclk;
  assign link.reset_powerdown_n = s_r.rst_n;
  assign link.sync_n            = s_r.sync_n;
  assign link.frame_sync_in_n   = s_r.wr_fs_n;
  assign link.sdi               = s_r.sdi;
  assign ready_o                = s_r.ready;
  assign rd_valid_o             = s_r.rd_valid;
  assign rd_word_o              = s_r.rd_word;
endmodule

// ==== dv/adc_startup_sync_sequencer_monitor.sv ====
// link checker: start-up order, pulse widths and frame lengths on the converter pins
// assumes one system clock and active-high async reset shared by both ends
`timescale 1ns/10ps
module adc_startup_sync_sequencer_monitor
  import adc_seq_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic mclk,
  input wire logic reset_powerdown_n,
  input wire logic sync_n,
  input wire logic frame_sync_in_n,
  input wire logic sdi,
  input wire logic serial_clock_out,
  input wire logic sdo,
  input wire logic frame_sync_out_n
);
  logic [15:0] rst_low_r;
  logic [15:0] sync_low_r;
  logic [15:0] wr_fs_low_r;
  logic [15:0] fso_low_r;
  logic        mclk_seen_r;

  // low-time counters: pulses are judged at their rising edge, so no long repetition is unrolled
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rst_low_r   <= 16'h0000;
      sync_low_r  <= 16'h0000;
      wr_fs_low_r <= 16'h0000;
      fso_low_r   <= 16'h0000;
      mclk_seen_r <= 1'b0;
    end else begin
      rst_low_r   <= reset_powerdown_n ? 16'h0000 : rst_low_r + 16'h0001;
      sync_low_r  <= sync_n ? 16'h0000 : sync_low_r + 16'h0001;
      wr_fs_low_r <= frame_sync_in_n ? 16'h0000 : wr_fs_low_r + 16'h0001;
      fso_low_r   <= frame_sync_out_n ? 16'h0000 : fso_low_r + 16'h0001;
      mclk_seen_r <= mclk_seen_r | mclk;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  chk_mclk_first: assert property ($fell(reset_powerdown_n) |-> mclk_seen_r)
    else $error("reset asserted before master clock ran");
  chk_rst_low_len: assert property ($rose(reset_powerdown_n) |-> rst_low_r >= 16'h0008)
    else $error("reset low shorter than one master period");
  chk_post_rst_wait: assert property ($rose(reset_powerdown_n) |-> (sync_n && frame_sync_in_n)[*8]
    ##1 (sync_n && frame_sync_in_n)[*8])
    else $error("activity within two master periods of reset release");
  chk_sync_vs_write: assert property (sync_n || frame_sync_in_n)
    else $error("sync pulse overlaps a write frame");
  chk_sync_low_len: assert property ($rose(sync_n) |-> sync_low_r >= 16'h0020)
    else $error("sync low shorter than four master periods");
  chk_mclk_period: assert property ($rose(mclk) |-> ##8 $rose(mclk))
    else $error("master clock period wrong");
  chk_sdi_timing: assert property (!frame_sync_in_n && $changed(sdi) |-> serial_clock_out)
    else $error("write data changed while serial clock low");
  chk_write_len: assert property ($rose(frame_sync_in_n) |-> wr_fs_low_r >= 16'h0200 && wr_fs_low_r <= 16'h0220)
    else $error("write frame length wrong");
  chk_read_frame_len: assert property ($rose(frame_sync_out_n) |-> fso_low_r == 16'h0200)
    else $error("read frame length wrong");

  cover property ($rose(sync_n));
  cover property ($rose(frame_sync_in_n));
  cover property ($rose(frame_sync_out_n));
endmodule

// ==== dv/tb_adc_startup_sync_sequencer.sv ====
// bench: host end and converter end joined over the link, checked from both user sides
// assumes 20 MHz clock; settling is counted from each restart of the filter
`timescale 1ns/10ps
module tb_adc_startup_sync_sequencer;
  import adc_seq_pkg::*;
  logic        clk_sys_i  = 1'b0;
  logic        rst_i      = 1'b1;
  logic        sync_en_i  = 1'b1;
  logic        sync_req_i = 1'b0;
  logic        wr_req_i   = 1'b0;
  logic [15:0] wr_addr_i  = 16'h0000;
  logic [15:0] wr_data_i  = 16'h0000;
  logic [1:0]  dec_rate_i = 2'h0;
  logic        ready_o, rd_valid_o, in_reset_o, settled_flag_o;
  logic        powered_down_o, low_power_o, ref_buf_off_o, amp_off_o;
  logic [31:0] rd_word_o;
  logic [15:0] gain_o, ovr_thr_o, gain_m, ovr_m, d;
  logic [3:0]  ctrl_m;
  logic        sync_seen = 1'b0;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          rd_bits[3] = '{CTRL_RD_OVR, CTRL_RD_GAIN, CTRL_RD_STAT};

  adc_link_if link ();
  adc_host_end i_adc_host_end (.clk_sys_i, .rst_i, .link(link), .sync_en_i, .sync_req_i, .wr_req_i,
    .wr_addr_i, .wr_data_i, .ready_o, .rd_valid_o, .rd_word_o);
  adc_dev_end i_adc_dev_end (.clk_sys_i, .rst_i, .link(link), .dec_rate_i, .in_reset_o, .settled_flag_o,
    .powered_down_o, .low_power_o, .ref_buf_off_o, .amp_off_o, .gain_o, .ovr_thr_o);
  adc_startup_sync_sequencer_monitor i_adc_startup_sync_sequencer_monitor (.clk_sys_i, .rst_i,
    .mclk(link.mclk), .reset_powerdown_n(link.reset_powerdown_n), .sync_n(link.sync_n),
    .frame_sync_in_n(link.frame_sync_in_n), .sdi(link.sdi), .serial_clock_out(link.serial_clock_out),
    .sdo(link.sdo), .frame_sync_out_n(link.frame_sync_out_n));

  always #25 clk_sys_i = ~clk_sys_i;

  // remembers any sync pulse since the last reset
  always @(posedge clk_sys_i) begin
    sync_seen <= rst_i ? 1'b0 : (sync_seen | (link.sync_n === 1'b0));
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // expected status word from the model state
  function automatic logic [15:0] stat_exp(input logic s);
    logic [15:0] v;
    v = STAT_FIXED;
    v[STAT_PART] = PART_BIT;
    v[STAT_SETTLED] = s;
    v[STAT_LPWR] = ctrl_m[2];
    v[STAT_REF_OFF] = ctrl_m[1];
    v[STAT_AMP_OFF] = ctrl_m[0];
    v[1:0] = dec_rate_i;
    return v;
  endfunction

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 3000) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk("ready", ready_o, 1'b1);
  endtask

  task automatic start_wr(input logic [15:0] a, input logic [15:0] v);
    wait_ready();
    wr_req_i  <= 1'b1;
    wr_addr_i <= a;
    wr_data_i <= v;
    @(posedge clk_sys_i);
    wr_req_i <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    start_wr(a, v);
    @(posedge clk_sys_i);
    chk("busy", ready_o, 1'b0);
    wait_ready();
    repeat (4) @(posedge clk_sys_i);
  endtask

  task automatic chk_regs();
    chk("gain", gain_o, gain_m);
    chk("ovr", ovr_thr_o, ovr_m);
    chk("ctrl", {powered_down_o, low_power_o, ref_buf_off_o, amp_off_o}, ctrl_m);
  endtask

  // settling must take about 64 master periods from the restart point
  task automatic settle();
    int n;
    n = 0;
    while (settled_flag_o !== 1'b1 && n < 1000) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk("settle_time", n >= 480 && n <= 540, 1'b1);
  endtask

  // the converter must follow the host's reset pulse on the pin
  task automatic pin_reset();
    int n;
    n = 0;
    while (link.reset_powerdown_n !== 1'b0 && n < 200) begin
      @(posedge clk_sys_i);
      n++;
    end
    repeat (9) @(posedge clk_sys_i);
    chk("in_reset_pin", in_reset_o, 1'b1);
  endtask

  // read-back request queues one frame; self-clearing bits never stick
  task automatic rd_back(input int bitpos);
    int          n;
    logic [15:0] hi;
    logic [15:0] st;
    // the frame's status half is captured with the control bits in force before this write
    st     = stat_exp(1'b1);
    ctrl_m = 4'($urandom);
    wr(ADDR_CTRL, (16'h0001 << bitpos) | {12'h000, ctrl_m});
    n = 0;
    while (rd_valid_o !== 1'b1 && n < 2000) begin
      @(posedge clk_sys_i);
      n++;
    end
    case (bitpos)
      CTRL_RD_OVR:  hi = ovr_m;
      CTRL_RD_GAIN: hi = gain_m;
      default:      hi = st;
    endcase
    chk("rd_word", rd_word_o, {hi, st});
    chk_regs();
  endtask

  initial begin
    void'($urandom(32'hF834));
    repeat (12) @(posedge clk_sys_i);
    rst_i      <= 1'b0;
    dec_rate_i <= 2'($urandom);
    pin_reset();
    wait_ready();
    gain_m = GAIN_RST;
    ovr_m  = OVR_RST;
    ctrl_m = 4'h0;
    chk_regs();
    chk("in_reset", in_reset_o, 1'b0);
    chk("sync_pulse", sync_seen, 1'b1);
    chk("settled_early", settled_flag_o, 1'b0);
    settle();
    $display("test startup done");
    // writes: all-zero and all-one corners, then random; every third address unmapped
    for (int i = 0; i < 9; i++) begin
      d = (i < 2) ? {16{i[0]}} : 16'($urandom);
      case (i % 3)
        0: begin
          wr(ADDR_GAIN, d);
          gain_m = d;
        end
        1: begin
          wr(ADDR_OVR, d);
          ovr_m = d;
        end
        default: wr(16'($urandom) | 16'h0100, d);
      endcase
      chk_regs();
    end
    $display("test writes done");
    foreach (rd_bits[k]) rd_back(rd_bits[k]);
    $display("test read back done");
    // pin sync, then control-bit sync; each restarts settling
    wait_ready();
    sync_req_i <= 1'b1;
    @(posedge clk_sys_i);
    sync_req_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    wait_ready();
    chk("settled_pin_sync", settled_flag_o, 1'b0);
    settle();
    wr(ADDR_CTRL, 16'h0200 | {12'h000, ctrl_m});
    chk("settled_ctrl_sync", settled_flag_o, 1'b0);
    chk_regs();
    settle();
    $display("test sync done");
    // reset in mid-write, restart without sync
    start_wr(ADDR_GAIN, ~gain_m);
    repeat (100) @(posedge clk_sys_i);
    rst_i     <= 1'b1;
    sync_en_i <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    pin_reset();
    wait_ready();
    gain_m = GAIN_RST;
    ovr_m  = OVR_RST;
    ctrl_m = 4'h0;
    chk_regs();
    chk("no_sync", sync_seen, 1'b0);
    chk("settled_reset", settled_flag_o, 1'b0);
    settle();
    $display("test second reset done");
    end_sim();
  end

  initial begin
    repeat (40000) @(posedge clk_sys_i);
    n_mismatch++;
    $display("[FAIL] watchdog expected done seen hang");
    end_sim();
  end
endmodule
